// *** tb/packet_bus_arbiter_framer_tb.sv ***
/* Testbench: controller end and watcher end on one bus, plus a second
   controller whose far end is driven directly to break the rules. */
`timescale 1ns/1ps
`default_nettype none
module packet_bus_arbiter_framer_tb;
  logic           sys_clk = 1'b0, sys_rst = 1'b1, tx_valid = 1'b0;
  logic           snd_valid = 1'b0, snd_high = 1'b0, snd_long = 1'b0;
  logic           snd_block = 1'b0, hold_off = 1'b0;
  logic           tx_ready, snd_ready, a_valid, w_valid, b_valid, b_mixed, b_err;
  logic [31:0]    tx_data = 32'h0, snd_hdr = 32'h0, word = 32'h0;
  logic [31:0]    a_data, last_hdr, last_dat;
  logic [3:0]     a_pend;
  pbus_pkg::cyc_t a_kind, w_kind, b_kind;
  int             n_errors = 0, comparisons = 0, ah, ad, wh, wd, i;
  pbus_if bus_a ();
  pbus_if bus_b ();
  always #50 sys_clk = ~sys_clk;
  packet_bus_arbiter_framer u_packet_bus_arbiter_framer (.sys_clk, .sys_rst,
    .bus(bus_a.ctl), .tx_valid, .tx_ready, .tx_data, .rx_valid(a_valid),
    .rx_kind(a_kind), .rx_data(a_data), .rx_mixed(), .code_error(),
    .pending_replies(a_pend));
  bus_watcher_end u_bus_watcher_end (.sys_clk, .sys_rst, .bus(bus_a.wat),
    .snd_valid, .snd_high, .snd_long, .snd_block, .snd_hdr, .snd_ready,
    .word_in(word), .word_take(), .hold_off, .rx_valid(w_valid),
    .rx_kind(w_kind), .rx_data(), .rx_mixed());
  packet_bus_arbiter_framer u_packet_bus_arbiter_framer_b (.sys_clk,
    .sys_rst, .bus(bus_b.ctl), .tx_valid(1'b0), .tx_ready(),
    .tx_data(32'h0), .rx_valid(b_valid), .rx_kind(b_kind), .rx_data(),
    .rx_mixed(b_mixed), .code_error(b_err), .pending_replies());
  pbus_assertions u_pbus_assertions (.sys_clk, .sys_rst,
    .ctl_oe_n(bus_a.ctl_oe_n), .wat_oe_n(bus_a.wat_oe_n),
    .bus_data(bus_a.bus_data), .parity_lane_bits(bus_a.parity_lane_bits),
    .watcher_request_pair(bus_a.watcher_request_pair),
    .bus_grant(bus_a.bus_grant));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task stop_test;
    $display("mismatches %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task give_up(input int n);
    if (n >= 20) begin
      n_errors++;
      stop_test;
    end
  endtask
  // Counts headers and data cycles seen by both ends of the first bus
  task watch(input int n);
    ah = 0; ad = 0; wh = 0; wd = 0;
    repeat (n) begin
      @(negedge sys_clk);
      if (a_valid === 1'b1 && a_kind === pbus_pkg::CYC_HEADER) begin
        ah++;
        last_hdr = a_data;
      end
      if (a_valid === 1'b1 && a_kind === pbus_pkg::CYC_DATA) begin
        ad++;
        last_dat = a_data;
      end
      if (w_valid === 1'b1 && w_kind === pbus_pkg::CYC_HEADER) wh++;
      if (w_valid === 1'b1 && w_kind === pbus_pkg::CYC_DATA) wd++;
    end
  endtask
  task send(input logic [2:0] k, input logic [31:0] hdr);
    {snd_high, snd_long, snd_block} = k;
    snd_hdr = hdr;
    snd_valid = 1'b1;
    for (i = 0; i < 20 && snd_ready !== 1'b1; i++) @(negedge sys_clk);
    snd_valid = 1'b0;
    give_up(i);
  endtask
  // Leaves tx_valid up so words go back to back
  task push(input logic [31:0] d);
    tx_data = d;
    tx_valid = 1'b1;
    for (i = 0; i < 20 && tx_ready !== 1'b1; i++) @(negedge sys_clk);
    give_up(i);
    @(negedge sys_clk);
  endtask
  task drive_b(input logic oe_n, input logic [31:0] d, input logic [3:0] p);
    bus_b.wat_oe_n = oe_n;
    bus_b.wat_data = d;
    bus_b.wat_par = p;
    @(negedge sys_clk);
  endtask
  task code_b(input logic [1:0] c);
    bus_b.watcher_request_pair = c;
    @(negedge sys_clk);
  endtask

  initial begin
    bus_b.wat_oe_n = 1'b1; bus_b.wat_data = 32'h0; bus_b.wat_par = 4'hF;
    bus_b.watcher_request_pair = 2'h3;
    repeat (6) @(negedge sys_clk);
    sys_rst = 1'b0;
    @(negedge sys_clk);
    chk(a_kind, pbus_pkg::CYC_IDLE);
    chk(a_pend, 4'h0);
    word = 32'h5A5A_00C3;
    // High, long, block: every legal request code pair
    for (int k = 0; k < 8; k++) begin
      if (k[2] && !k[1]) continue;
      send(k[2:0], {16'h0, 8'(k), 2'h0, k[1], 5'h01});
      watch(30);
      chk(ah, 1);
      chk(ad, k[1] ? 8 : 1);
      chk(last_hdr, {16'h0, 8'(k), 2'h0, k[1], 5'h01});
      chk(last_dat, word);
    end
    hold_off = 1'b1;
    repeat (2) @(negedge sys_clk);
    hold_off = 1'b0;
    // Watch from the first push so the controller's own header is seen
    fork
      begin
        push(32'hABC0_0023);
        for (int k = 1; k < 9; k++) push(32'h0000_1000 + k);
        tx_valid = 1'b0;
      end
      watch(60);
    join
    chk(wh, 2);
    chk(wd, 9);
    chk(ah, 2);
    chk(last_hdr, pbus_pkg::AUTO_REPLY_HDR);
    chk(last_dat, 32'h0);
    chk(a_pend, 4'h0);
    drive_b(1'b0, 32'h0000_0001, 4'h1);
    chk(b_kind, pbus_pkg::CYC_HEADER);
    drive_b(1'b0, 32'h0, 4'h0);
    chk(b_kind, pbus_pkg::CYC_MEMORY_FAULT);
    drive_b(1'b1, 32'h0, 4'hF);
    chk(b_valid, 1'b0);
    drive_b(1'b0, 32'h0, 4'h1);
    chk(b_mixed, 1'b1);
    drive_b(1'b1, 32'h0, 4'hF);
    for (int k = 2; k < 4; k++) begin
      code_b(2'h0);
      code_b(2'(k));
      chk(b_err, 1'b1);
      code_b(2'h3);
    end
    code_b(2'h1);
    code_b(2'h3);
    for (i = 0; i < 20 && bus_b.bus_grant !== 1'b1; i++) @(negedge sys_clk);
    chk(i < 20, 1'b1);
    stop_test;
  end
endmodule
`default_nettype wire

// *** tb/pbus_assertions.sv ***
/* Checker for the packet bus between the two ends.
   Takes the interface signals as plain inputs; one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module pbus_assertions (
  // Clock, reset and bus signals
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        ctl_oe_n,
  input wire logic        wat_oe_n,
  input wire logic [31:0] bus_data,
  input wire logic [3:0]  parity_lane_bits,
  input wire logic [1:0]  watcher_request_pair,
  input wire logic        bus_grant
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic [3:0] ev;
  logic [3:0] run;
  assign ev = {~^{bus_data[31:24], parity_lane_bits[3]},
               ~^{bus_data[23:16], parity_lane_bits[2]},
               ~^{bus_data[15:8], parity_lane_bits[1]},
               ~^{bus_data[7:0], parity_lane_bits[0]}};
  // Saturates so a stuck driver cannot wrap back to a legal length
  always_ff @(posedge sys_clk) begin
    if (sys_rst || wat_oe_n) run <= 4'h0;
    else if (run != 4'hF) run <= run + 4'h1;
  end
  a_single_driver: assert property (ctl_oe_n || wat_oe_n)
    else $error("both ends drive the bus");
  a_grant_pulse: assert property (bus_grant |=> !bus_grant)
    else $error("grant longer than one cycle");
  a_grant_then_send: assert property (bus_grant |=> !wat_oe_n && ctl_oe_n)
    else $error("grant not followed by watcher packet");
  a_packet_length: assert property ($rose(wat_oe_n) |-> run == 4'h2 || run == 4'h9)
    else $error("packet length not two or nine");
  a_header_even: assert property ($fell(wat_oe_n) |-> ev == 4'hF)
    else $error("header without all-even lanes");
  a_data_odd: assert property (!wat_oe_n && !$fell(wat_oe_n) |-> ev == 4'h0)
    else $error("data cycle without all-odd lanes");
  a_request_granted: assert property (($past(watcher_request_pair) == 2'h1 &&
      watcher_request_pair == 2'h3) |-> ##[0:40] bus_grant)
    else $error("watcher request not granted");
  a_block_all: assert property ((watcher_request_pair == 2'h2 &&
      $past(watcher_request_pair) == 2'h2) |-> ##3 (!$fell(ctl_oe_n))[*5])
    else $error("controller sent inside blocking window");
endmodule
`default_nettype wire

// *** verilog/bus_watcher_end.sv ***
/*
  Bus watcher end: asks for the bus over the two request lines, sends
  its packet on grant and frames every cycle it sees on the bus.
  Assumes the controller end sits on the same clock across pbus_if.
*/
`timescale 1ns/1ps
`default_nettype none
module bus_watcher_end (
  // Clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    sys_rst,
  // Packet bus
  pbus_if.wat                          bus,
  // Send request
  input  wire logic                    snd_valid,
  input  wire logic                    snd_high,
  input  wire logic                    snd_long,
  input  wire logic                    snd_block,
  input  wire logic [pbus_pkg::DW-1:0] snd_hdr,
  output logic                         snd_ready,
  input  wire logic [pbus_pkg::DW-1:0] word_in,
  output logic                         word_take,
  input  wire logic                    hold_off,
  // Received cycles
  output logic                         rx_valid,
  output pbus_pkg::cyc_t               rx_kind,
  output logic [pbus_pkg::DW-1:0]      rx_data,
  output logic                         rx_mixed
);
  typedef enum logic [1:0] {W_IDLE, W_CODE2, W_WAIT, W_SEND} wat_st_t;

  wat_st_t                 wst;
  logic                    hi;
  logic                    lng;
  logic                    blk;
  logic                    is_auto;
  logic [pbus_pkg::DW-1:0] hdr;
  logic [3:0]              left;
  logic [3:0]              rx_left;
  logic [3:0]              even_l;
  logic                    auto_pend;
  logic                    auto_take;

  assign even_l = pbus_pkg::lane_even(bus.bus_data, bus.parity_lane_bits);
  assign auto_take = (wst == W_IDLE) && auto_pend;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rx_left <= '0;
      rx_valid <= 1'b0;
      rx_kind <= pbus_pkg::CYC_IDLE;
      rx_data <= '0;
      rx_mixed <= 1'b0;
      auto_pend <= 1'b0;
    end else begin
      rx_data <= bus.bus_data;
      rx_mixed <= 1'b0;
      rx_valid <= 1'b1;
      if (auto_take) begin
        auto_pend <= 1'b0;
      end
      if (even_l == pbus_pkg::ALL_LANES && rx_left == '0) begin
        rx_kind <= pbus_pkg::CYC_HEADER;
        rx_left <= bus.bus_data[pbus_pkg::LEN_BIT]
                 ? pbus_pkg::LEN_LONG - 4'h1 : pbus_pkg::LEN_SHORT - 4'h1;
        // Block write request from the far end wants a short reply
        if (bus.wat_oe_n && bus.bus_data[pbus_pkg::LEN_BIT]
            && !bus.bus_data[pbus_pkg::REPLY_BIT]
            && bus.bus_data[pbus_pkg::TYPE_MSB:0]
               == pbus_pkg::TYPE_BLOCK_WRITE) begin
          auto_pend <= 1'b1;
        end
      end else if (even_l == pbus_pkg::ALL_LANES) begin
        rx_kind <= pbus_pkg::CYC_MEMORY_FAULT;
        rx_left <= rx_left - 4'h1;
      end else if (even_l == pbus_pkg::NO_LANES) begin
        rx_kind <= (rx_left != '0) ? pbus_pkg::CYC_DATA
                                   : pbus_pkg::CYC_IDLE;
        rx_valid <= (rx_left != '0);
        if (rx_left != '0) begin
          rx_left <= rx_left - 4'h1;
        end
      end else begin
        rx_kind <= pbus_pkg::CYC_IDLE;
        rx_valid <= 1'b0;
        rx_mixed <= 1'b1;
        if (rx_left != '0) begin
          rx_left <= rx_left - 4'h1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wst <= W_IDLE;
      bus.watcher_request_pair <= pbus_pkg::CODE_HH;
      snd_ready <= 1'b0;
      hi <= 1'b0;
      lng <= 1'b0;
      blk <= 1'b0;
      is_auto <= 1'b0;
      hdr <= '0;
      left <= '0;
    end else begin
      snd_ready <= 1'b0;
      bus.watcher_request_pair <= pbus_pkg::CODE_HH;
      case (wst)
        W_IDLE: begin
          if (auto_pend) begin
            hi <= 1'b0;
            lng <= 1'b0;
            blk <= 1'b0;
            is_auto <= 1'b1;
            hdr <= pbus_pkg::AUTO_REPLY_HDR;
            bus.watcher_request_pair <= pbus_pkg::CODE_LH;
            wst <= W_CODE2;
          end else if (snd_valid) begin
            hi <= snd_high;
            lng <= snd_high | snd_long;
            blk <= snd_block;
            is_auto <= 1'b0;
            hdr <= snd_hdr;
            hdr[pbus_pkg::LEN_BIT] <= snd_high | snd_long;
            snd_ready <= 1'b1;
            bus.watcher_request_pair <= snd_high ? pbus_pkg::CODE_LL
                                                 : pbus_pkg::CODE_LH;
            wst <= W_CODE2;
          end else if (hold_off) begin
            bus.watcher_request_pair <= pbus_pkg::CODE_HL;
          end
        end
        W_CODE2: begin
          // High priority only ever sends LH or LL second
          if (hi) begin
            bus.watcher_request_pair <= blk ? pbus_pkg::CODE_LL
                                            : pbus_pkg::CODE_LH;
          end else begin
            bus.watcher_request_pair <= {~lng, ~blk};
          end
          wst <= W_WAIT;
        end
        W_WAIT: begin
          if (bus.bus_grant) begin
            left <= (lng ? pbus_pkg::LEN_LONG : pbus_pkg::LEN_SHORT)
                  - 4'h1;
            wst <= W_SEND;
          end
        end
        W_SEND: begin
          left <= left - 4'h1;
          if (left == 4'h1) begin
            wst <= W_IDLE;
          end
        end
        default: wst <= W_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bus.wat_oe_n <= 1'b1;
      bus.wat_data <= '0;
      bus.wat_par <= pbus_pkg::PAR_IDLE;
      word_take <= 1'b0;
    end else if (wst == W_WAIT && bus.bus_grant) begin
      bus.wat_oe_n <= 1'b0;
      bus.wat_data <= hdr;
      bus.wat_par <= pbus_pkg::par_gen(hdr, 1'b1);
      word_take <= 1'b0;
    end else if (wst == W_SEND) begin
      bus.wat_oe_n <= 1'b0;
      bus.wat_data <= is_auto ? '0 : word_in;
      bus.wat_par <= pbus_pkg::par_gen(is_auto ? '0 : word_in, 1'b0);
      word_take <= !is_auto;
    end else begin
      bus.wat_oe_n <= 1'b1;
      bus.wat_data <= '0;
      bus.wat_par <= pbus_pkg::PAR_IDLE;
      word_take <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** verilog/packet_bus_arbiter_framer.sv ***
/*
  Controller end of the packet bus: frames every bus cycle, decodes the
  watcher's two-cycle request codes, arbitrates four priority levels
  with flow-control blocking, and sends its own queued packets.
  Assumes the watcher end runs on the same clock across pbus_if and
  that the feeder keeps pace once a long packet has started.
*/
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Each cycle is header, data, fault or idle
// - All-even opens packet, else memory fault
// - All-odd is data inside packet, else idle
// - Mixed lane parity flags an error
// - Header from four even lanes plus state
// - Packets last exactly two or nine cycles
// - Header length bit loads packet counter
// - Send only after grant, never interrupted
// - Five-bit command: reply flag plus type
// - Requests pair with replies, flush or timeout
// - Watcher meaning decoded over two cycles
// - HL blocks requests; HL HL blocks all
// - LH then code picks low size, block
// - LL then LH/LL high nine; others invalid
// - Priority: watcher high, replies, low, requests
// - Watcher grant spans two or nine cycles
// - Block write request answered by short reply
module packet_bus_arbiter_framer (
  // Clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    sys_rst,
  // Packet bus
  pbus_if.ctl                          bus,
  // Outgoing packet words, header first
  input  wire logic                    tx_valid,
  output logic                         tx_ready,
  input  wire logic [pbus_pkg::DW-1:0] tx_data,
  // Received cycles
  output logic                         rx_valid,
  output pbus_pkg::cyc_t               rx_kind,
  output logic [pbus_pkg::DW-1:0]      rx_data,
  output logic                         rx_mixed,
  // Status
  output logic                         code_error,
  output logic [3:0]                   pending_replies
);
  typedef enum logic [1:0] {
    DEC_FIRST, DEC_AFTER_HL, DEC_AFTER_LH, DEC_AFTER_LL
  } dec_t;

  logic [pbus_pkg::DW-1:0] head;
  logic                    head_valid;
  logic [3:0]              level;
  logic                    pop;
  logic [3:0]              need;
  logic                    own_reply;
  logic                    own_ok;
  logic [3:0]              even_l;
  logic [3:0]              rx_left;
  dec_t                    dec;
  logic [1:0]              code;
  logic [3:0]              req_blk;
  logic [3:0]              all_blk;
  logic                    pend_hi;
  logic                    pend_lo;
  logic                    pend_long;
  logic                    grant_wat;
  logic                    grant_own;
  logic                    own_go;
  logic [3:0]              bus_left;
  logic [3:0]              ctl_left;
  logic                    sent_req;
  logic                    got_reply;
  logic [3:0]              next_pending;

  // First code of a pair decides which table half follows
  function automatic dec_t after_first(input logic [1:0] c);
    case (c)
      pbus_pkg::CODE_HL: after_first = DEC_AFTER_HL;
      pbus_pkg::CODE_LH: after_first = DEC_AFTER_LH;
      pbus_pkg::CODE_LL: after_first = DEC_AFTER_LL;
      default: after_first = DEC_FIRST;
    endcase
  endfunction

  // Queued words wait here; the sender stalls until the packet or a
  // full queue is in
  packet_fifo #(
    .WIDTH (pbus_pkg::DW),
    .DEPTH (pbus_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_data),
    .out_valid (head_valid),
    .out_ready (pop),
    .out_data  (head),
    .level     (level)
  );

  assign code = bus.watcher_request_pair;
  assign even_l = pbus_pkg::lane_even(bus.bus_data, bus.parity_lane_bits);
  assign need = head[pbus_pkg::LEN_BIT] ? pbus_pkg::LEN_LONG
                                        : pbus_pkg::LEN_SHORT;
  assign own_reply = head[pbus_pkg::REPLY_BIT];
  // A long packet cannot fit an 8-word queue, so a full queue may start
  // it; the feeder must then keep up or the tail words come out stale
  assign own_ok = head_valid && (ctl_left == '0)
                && (level >= need
                    || level == 4'(pbus_pkg::FIFO_DEPTH));
  assign pop = own_go || (ctl_left != '0);

  // Receive side packet tracker
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rx_left <= '0;
      rx_valid <= 1'b0;
      rx_kind <= pbus_pkg::CYC_IDLE;
      rx_data <= '0;
      rx_mixed <= 1'b0;
    end else begin
      rx_data <= bus.bus_data;
      rx_mixed <= 1'b0;
      rx_valid <= 1'b1;
      if (even_l == pbus_pkg::ALL_LANES && rx_left == '0) begin
        rx_kind <= pbus_pkg::CYC_HEADER;
        rx_left <= need_of(bus.bus_data) - 4'h1;
      end else if (even_l == pbus_pkg::ALL_LANES) begin
        rx_kind <= pbus_pkg::CYC_MEMORY_FAULT;
        rx_left <= rx_left - 4'h1;
      end else if (even_l == pbus_pkg::NO_LANES) begin
        // Odd parity alone cannot tell data from idle
        rx_kind <= (rx_left != '0) ? pbus_pkg::CYC_DATA
                                   : pbus_pkg::CYC_IDLE;
        rx_valid <= (rx_left != '0);
        if (rx_left != '0) begin
          rx_left <= rx_left - 4'h1;
        end
      end else begin
        rx_kind <= pbus_pkg::CYC_IDLE;
        rx_valid <= 1'b0;
        rx_mixed <= 1'b1;
        if (rx_left != '0) begin
          rx_left <= rx_left - 4'h1;
        end
      end
    end
  end

  function automatic logic [3:0] need_of(input logic [pbus_pkg::DW-1:0] h);
    need_of = h[pbus_pkg::LEN_BIT] ? pbus_pkg::LEN_LONG
                                   : pbus_pkg::LEN_SHORT;
  endfunction

  // Outstanding requests; a flush may answer more than once, a
  // timeout never, so the count only floors at zero
  assign sent_req = own_go && !own_reply;
  assign got_reply = rx_kind == pbus_pkg::CYC_HEADER && rx_valid
                   && rx_data[pbus_pkg::REPLY_BIT] && bus.ctl_oe_n
                   && (pending_replies != '0);
  always_comb begin
    next_pending = pending_replies;
    if (sent_req && !got_reply) begin
      next_pending = pending_replies + 4'h1;
    end else if (got_reply && !sent_req) begin
      next_pending = pending_replies - 4'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pending_replies <= '0;
    end else begin
      pending_replies <= next_pending;
    end
  end

  // Request code decoder and flow-control windows
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dec <= DEC_FIRST;
      req_blk <= '0;
      all_blk <= '0;
      pend_hi <= 1'b0;
      pend_lo <= 1'b0;
      pend_long <= 1'b0;
      code_error <= 1'b0;
    end else begin
      code_error <= 1'b0;
      if (req_blk != '0) begin
        req_blk <= req_blk - 4'h1;
      end
      if (all_blk != '0) begin
        all_blk <= all_blk - 4'h1;
      end
      if (grant_wat) begin
        pend_hi <= 1'b0;
        pend_lo <= 1'b0;
      end
      case (dec)
        DEC_FIRST: begin
          dec <= after_first(code);
          if (code == pbus_pkg::CODE_HL) begin
            req_blk <= pbus_pkg::BLOCK_CYCLES;
          end
        end
        DEC_AFTER_HL: begin
          if (code == pbus_pkg::CODE_HL) begin
            all_blk <= pbus_pkg::BLOCK_CYCLES;
            dec <= DEC_FIRST;
          end else begin
            dec <= after_first(code);
          end
        end
        DEC_AFTER_LH: begin
          pend_lo <= 1'b1;
          pend_long <= ~code[1];
          if (!code[0]) begin
            all_blk <= pbus_pkg::BLOCK_CYCLES;
          end
          dec <= DEC_FIRST;
        end
        DEC_AFTER_LL: begin
          if (code == pbus_pkg::CODE_LH || code == pbus_pkg::CODE_LL) begin
            pend_hi <= 1'b1;
            pend_long <= 1'b1;
            if (code == pbus_pkg::CODE_LL) begin
              all_blk <= pbus_pkg::BLOCK_CYCLES;
            end
          end else begin
            code_error <= 1'b1;
          end
          dec <= DEC_FIRST;
        end
        default: dec <= DEC_FIRST;
      endcase
    end
  end

  // Fixed priority; nothing is granted while a packet still runs
  always_comb begin
    grant_wat = 1'b0;
    grant_own = 1'b0;
    if (bus_left == '0) begin
      if (pend_hi) begin
        grant_wat = 1'b1;
      end else if (own_ok && own_reply && all_blk == '0) begin
        grant_own = 1'b1;
      end else if (pend_lo) begin
        grant_wat = 1'b1;
      end else if (own_ok && !own_reply && all_blk == '0
                   && req_blk == '0) begin
        grant_own = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bus.bus_grant <= 1'b0;
      own_go <= 1'b0;
      bus_left <= '0;
    end else begin
      bus.bus_grant <= grant_wat;
      own_go <= grant_own;
      if (grant_wat) begin
        bus_left <= pend_long ? pbus_pkg::LEN_LONG
                              : pbus_pkg::LEN_SHORT;
      end else if (grant_own) begin
        bus_left <= need;
      end else if (bus_left != '0) begin
        bus_left <= bus_left - 4'h1;
      end
    end
  end

  // Own transmitter: header then every data word back to back
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctl_left <= '0;
      bus.ctl_oe_n <= 1'b1;
      bus.ctl_data <= '0;
      bus.ctl_par <= pbus_pkg::PAR_IDLE;
    end else if (own_go) begin
      bus.ctl_oe_n <= 1'b0;
      bus.ctl_data <= head;
      bus.ctl_par <= pbus_pkg::par_gen(head, 1'b1);
      ctl_left <= need - 4'h1;
    end else if (ctl_left != '0) begin
      bus.ctl_oe_n <= 1'b0;
      bus.ctl_data <= head;
      bus.ctl_par <= pbus_pkg::par_gen(head, 1'b0);
      ctl_left <= ctl_left - 4'h1;
    end else begin
      bus.ctl_oe_n <= 1'b1;
      bus.ctl_data <= '0;
      bus.ctl_par <= pbus_pkg::PAR_IDLE;
    end
  end
endmodule
`default_nettype wire

// *** verilog/packet_fifo.sv ***
/*
  Word FIFO with valid/ready on both sides and a fill level.
  Assumes DEPTH is a power of two so the pointers wrap by themselves.
*/
`timescale 1ns/1ps
`default_nettype none
module packet_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       sys_rst,
  // Fill side
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  // Drain side
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [WIDTH-1:0]                out_data,
  output logic [$clog2(DEPTH+1)-1:0]      level
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    rd_ptr;
  logic [AW-1:0]    wr_ptr;
  logic             push;
  logic             pop;

  assign in_ready = (level != LW'(DEPTH));
  assign out_valid = (level != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      level <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        level <= level + 1'b1;
      end else if (pop && !push) begin
        level <= level - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** verilog/pbus_if.sv ***
/*
  Packet bus between the controller end and one bus watcher end.
  Assumes each end drives only while its enable is low; the bus
  rests at all-odd parity with zero data when nobody drives.
*/
`timescale 1ns/1ps
`default_nettype none
interface pbus_if;
  logic [pbus_pkg::DW-1:0] ctl_data;
  logic [3:0]              ctl_par;
  logic                    ctl_oe_n;
  logic [pbus_pkg::DW-1:0] wat_data;
  logic [3:0]              wat_par;
  logic                    wat_oe_n;
  logic [pbus_pkg::DW-1:0] bus_data;
  logic [3:0]              parity_lane_bits;
  logic [1:0]              watcher_request_pair;
  logic                    bus_grant;

  assign bus_data = !ctl_oe_n ? ctl_data
                  : (!wat_oe_n ? wat_data : '0);
  assign parity_lane_bits = !ctl_oe_n ? ctl_par
                          : (!wat_oe_n ? wat_par : pbus_pkg::PAR_IDLE);

  modport ctl (output ctl_data, ctl_par, ctl_oe_n, bus_grant,
               input bus_data, parity_lane_bits, watcher_request_pair);
  modport wat (output wat_data, wat_par, wat_oe_n, watcher_request_pair,
               input bus_data, parity_lane_bits, bus_grant);
endinterface
`default_nettype wire

// *** verilog/pbus_pkg.sv ***
/*
  Shared constants, cycle kinds and parity helpers for the packet bus.
  Assumes one bus clock for both ends; 32 data bits in four byte lanes.
*/
`default_nettype none
package pbus_pkg;
  localparam int DW = 32;
  localparam int LANES = 4;
  localparam int LANE_W = 8;
  localparam int FIFO_DEPTH = 8;
  // Request line codes: bit 1 then bit 0, high reads as 1
  localparam logic [1:0] CODE_HH = 2'h3;
  localparam logic [1:0] CODE_HL = 2'h2;
  localparam logic [1:0] CODE_LH = 2'h1;
  localparam logic [1:0] CODE_LL = 2'h0;
  localparam logic [3:0] LEN_SHORT = 4'h2;
  localparam logic [3:0] LEN_LONG = 4'h9;
  localparam logic [3:0] BLOCK_CYCLES = 4'h9;
  localparam logic [3:0] ALL_LANES = 4'hF;
  localparam logic [3:0] NO_LANES = 4'h0;
  localparam logic [3:0] PAR_IDLE = 4'hF;
  // Header layout: type in 3:0, reply flag, then length flag
  localparam int TYPE_MSB = 3;
  localparam int REPLY_BIT = 4;
  localparam int LEN_BIT = 5;
  localparam logic [3:0] TYPE_BLOCK_WRITE = 4'h3;
  localparam logic [DW-1:0] AUTO_REPLY_HDR = DW'({1'b1, TYPE_BLOCK_WRITE});

  typedef enum logic [1:0] {
    CYC_IDLE, CYC_HEADER, CYC_DATA, CYC_MEMORY_FAULT
  } cyc_t;

  // One bit per lane: lane carries an even count of ones
  function automatic logic [LANES-1:0] lane_even(
    input logic [DW-1:0] d, input logic [LANES-1:0] p);
    for (int i = 0; i < LANES; i++)
      lane_even[i] = ~^{d[i*LANE_W +: LANE_W], p[i]};
  endfunction

  function automatic logic [LANES-1:0] par_gen(
    input logic [DW-1:0] d, input logic even);
    for (int i = 0; i < LANES; i++)
      par_gen[i] = ^d[i*LANE_W +: LANE_W] ^ ~even;
  endfunction
endpackage
`default_nettype wire
